/* logic/moc_freq_gen.sv */
module moc_freq_gen (
  input wire logic i_clk,
  input wire logic i_nrst,
  moc_freq_if.gen fif
);
  logic [31:0] acc; // phase accumulator
  logic phase; // output phase, toggles twice per output period
  logic [moc_pkg::RATE_W-1:0] rate_lim; // rate clamped to full scale
  logic [31:0] limit; // accumulator wrap point
  logic [31:0] sum;

  // above full scale the output stays at the full-scale frequency
  assign rate_lim = (fif.rate > fif.full) ? fif.full : fif.rate;
  // wrap point: full scale times half-period cycles, so frequency is linear in rate
  assign limit = 32'(fif.full) * moc_pkg::FREQ_HALF_DIV;
  assign sum = acc + 32'(rate_lim);

  // phase accumulator; a zero full scale stops the output instead of racing
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      acc <= 32'h0000_0000;
      phase <= 1'b0;
    end
    else if (!fif.en || limit == 32'h0000_0000)
    begin
      acc <= 32'h0000_0000;
      phase <= 1'b0;
    end
    else if (sum >= limit)
    begin
      acc <= sum - limit; // keep the remainder so the mean rate is exact
      phase <= ~phase;
    end
    else
    begin
      acc <= sum;
    end
  end

  // route the phase to the waveform that the switch selects
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fif.sq <= 1'b0;
      fif.turb <= 1'b0;
    end
    else
    begin
      fif.sq <= fif.en & fif.sq_sel & phase;
      fif.turb <= fif.en & ~fif.sq_sel & phase;
    end
  end

  chk_zero_rate_still: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (fif.rate == '0 && fif.en) |=> $stable(phase))
  else $error("phase moved with zero flow rate");
endmodule

/* logic/moc_freq_if.sv */
interface moc_freq_if;
  logic [moc_pkg::RATE_W-1:0] rate; // measured flow rate
  logic [moc_pkg::RATE_W-1:0] full; // rate that gives full-scale frequency
  logic en; // low while the service cable is attached
  logic sq_sel; // waveform switch: high square, low turbine
  logic sq; // square-wave drive
  logic turb; // turbine-simulation drive
  modport ctl (output rate, full, en, sq_sel, input sq, turb);
  modport gen (input rate, full, en, sq_sel, output sq, turb);
endinterface

/* logic/moc_pkg.sv */
package moc_pkg;
  // clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TOT_PULSE_MS = 100; // totalizer pulse width
  localparam int TOT_MIN_PERIOD_MS = 1000; // one pulse per second at most
  localparam int TOT_PULSE_CYC = CLK_HZ / MS_PER_S * TOT_PULSE_MS;
  localparam int TOT_PERIOD_CYC = CLK_HZ / MS_PER_S * TOT_MIN_PERIOD_MS;
  // frequency output scaling: full scale gives this many hertz
  localparam int FREQ_FULL_HZ = 1000;
  localparam int SEC_PER_MIN = 60;
  localparam int K_NUMERATOR = FREQ_FULL_HZ * SEC_PER_MIN; // 60000 pulses per minute at full scale
  // clock cycles per half period at full scale, folded into the accumulator limit
  localparam logic [31:0] FREQ_HALF_DIV = 32'(CLK_HZ * SEC_PER_MIN / (2 * K_NUMERATOR));
  // widths
  localparam int RATE_W = 16;
  localparam int ECHO_W = 8;
  localparam int MODE_W = 3;
  localparam int EXP_W = 3;
  localparam int PEND_W = 16;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE_ON = 8'h04;
  localparam logic [7:0] OFS_RATE_OFF = 8'h08;
  localparam logic [7:0] OFS_ECHO_ON = 8'h0c;
  localparam logic [7:0] OFS_ECHO_OFF = 8'h10;
  localparam logic [7:0] OFS_DIVISOR = 8'h14;
  localparam logic [7:0] OFS_EXPONENT = 8'h18;
  localparam logic [7:0] OFS_FULL_SCALE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_TOTAL = 8'h24;
  // control register field positions
  localparam int CTRL_OUT1_LSB = 0;
  localparam int CTRL_OUT2_LSB = 4;
  // status register field positions
  localparam int ST_OUT1 = 0;
  localparam int ST_OUT2 = 1;
  localparam int ST_USB = 2;
  localparam int ST_RATE_AL = 3;
  localparam int ST_ECHO_AL = 4;
  localparam int ST_PEND_LSB = 16;
  // reset values
  localparam logic [RATE_W-1:0] RATE_ON_RST = 16'hffff;
  localparam logic [RATE_W-1:0] RATE_OFF_RST = 16'h0000;
  localparam logic [ECHO_W-1:0] ECHO_ON_RST = 8'h05;
  localparam logic [ECHO_W-1:0] ECHO_OFF_RST = 8'h0a;
  localparam logic [RATE_W-1:0] DIVISOR_RST = 16'h0001;
  localparam logic [RATE_W-1:0] FULL_SCALE_RST = 16'h0190;
  // function of one control output, encoded in the order listed
  typedef enum logic [MODE_W-1:0] {MODE_NONE, MODE_RATE, MODE_ECHO, MODE_TOTAL, MODE_ERROR} moc_mode_type;
  // totalizer pulse sequencer
  typedef enum logic [1:0] {TP_IDLE, TP_HIGH, TP_GAP} moc_tp_type;
endpackage

/* logic/moc_top.sv */
// Our own choices: register access over APB and the register addresses.
module moc_top #(
  parameter int P_PULSE_CYC = moc_pkg::TOT_PULSE_CYC,
  parameter int P_PERIOD_CYC = moc_pkg::TOT_PERIOD_CYC
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [moc_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [moc_pkg::RATE_W-1:0] I_FLOW_RATE,
  input wire logic [moc_pkg::ECHO_W-1:0] I_ECHO_LEVEL,
  input wire logic I_TOTAL_TICK,
  input wire logic I_FAULT,
  input wire logic I_USB_CONNECTED,
  input wire logic I_NRESET_TOTAL,
  input wire logic I_FREQ_WAVEFORM_SELECT_SWITCH,
  output logic O_CTRL_OUT1,
  output logic O_CTRL_OUT2,
  output logic O_FREQ_SQUARE,
  output logic O_FREQ_TURBINE,
  output logic O_RS485_ENABLE
);
  // software registers
  logic [moc_pkg::MODE_W-1:0] mode1; // output one function code
  logic [moc_pkg::MODE_W-1:0] mode2; // output two function code
  logic [moc_pkg::RATE_W-1:0] rate_on; // rate alarm switch-on point
  logic [moc_pkg::RATE_W-1:0] rate_off; // rate alarm switch-off point
  logic [moc_pkg::ECHO_W-1:0] echo_on; // echo_level_alarm switch-on point
  logic [moc_pkg::ECHO_W-1:0] echo_off; // echo_level_alarm switch-off point
  logic [moc_pkg::RATE_W-1:0] total_pulse_divisor;
  logic [moc_pkg::EXP_W-1:0] total_decade_exponent;
  logic [moc_pkg::RATE_W-1:0] full_scale; // rate for full-scale frequency
  // alarm and totalizer state
  logic rate_alarm;
  logic echo_level_alarm;
  logic [23:0] decade_cnt; // raw ticks within one displayed count
  logic [moc_pkg::RATE_W-1:0] div_cnt; // displayed counts within one pulse
  logic [31:0] total; // displayed total
  logic [moc_pkg::PEND_W-1:0] pending; // pulses owed to the output
  moc_pkg::moc_tp_type tp_state;
  logic [31:0] tp_timer;
  logic tot_pulse;
  // bus side and totalizer strobes
  logic setup;
  logic wr_take;
  logic disp_inc;
  logic pulse_req;
  logic pulse_start;
  logic [31:0] status_word;

  moc_freq_if fif ();

  // ten to the power e; a count of the exponent setting, at most 10^7
  function automatic logic [23:0] pow10(input logic [moc_pkg::EXP_W-1:0] e);
    logic [23:0] p;
    p = 24'h00_0001;
    for (int k = 0; k < 7; k++)
    begin
      if (k < int'(e))
      begin
        p = 24'(p * 24'h00_000a);
      end
    end
    return p;
  endfunction

  // hysteresis: a hit on the set side wins, a hit on the clear side releases, else hold
  function automatic logic hyst(input logic prev, input logic hit_on, input logic hit_off);
    return hit_on ? 1'b1 : (hit_off ? 1'b0 : prev);
  endfunction

  // level of one control output for its function; unknown codes read as inactive
  function automatic logic out_level(input logic [moc_pkg::MODE_W-1:0] code, input logic ra,
                                     input logic ea, input logic tp, input logic flt);
    logic v;
    v = 1'b0;
    unique case (moc_pkg::moc_mode_type'(code))
      moc_pkg::MODE_NONE: v = 1'b0;
      moc_pkg::MODE_RATE: v = ra;
      moc_pkg::MODE_ECHO: v = ea;
      moc_pkg::MODE_TOTAL: v = tp;
      moc_pkg::MODE_ERROR: v = flt;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // address decode for the error answer; the read mux decodes the same offsets in its own case
  function automatic logic mapped(input logic [moc_pkg::ADDR_W-1:0] a);
    return a == moc_pkg::OFS_CTRL || a == moc_pkg::OFS_RATE_ON || a == moc_pkg::OFS_RATE_OFF ||
           a == moc_pkg::OFS_ECHO_ON || a == moc_pkg::OFS_ECHO_OFF || a == moc_pkg::OFS_DIVISOR ||
           a == moc_pkg::OFS_EXPONENT || a == moc_pkg::OFS_FULL_SCALE || a == moc_pkg::OFS_STATUS ||
           a == moc_pkg::OFS_TOTAL;
  endfunction

  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_take = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

  // pready answers one cycle after setup: zero wait states
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY <= setup;
      O_PSLVERR <= setup & ~mapped(I_PADDR); // unmapped or misaligned address
    end
  end

  assign status_word = {16'(pending), 11'h000, echo_level_alarm, rate_alarm, I_USB_CONNECTED,
                        O_CTRL_OUT2, O_CTRL_OUT1};

  // read data is captured in the setup cycle so it stands through the access phase
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_PRDATA <= 32'h0000_0000;
    end
    else if (setup && !I_PWRITE)
    begin
      unique case (I_PADDR)
        moc_pkg::OFS_CTRL: O_PRDATA <= 32'({mode2, 1'b0, mode1});
        moc_pkg::OFS_RATE_ON: O_PRDATA <= 32'(rate_on);
        moc_pkg::OFS_RATE_OFF: O_PRDATA <= 32'(rate_off);
        moc_pkg::OFS_ECHO_ON: O_PRDATA <= 32'(echo_on);
        moc_pkg::OFS_ECHO_OFF: O_PRDATA <= 32'(echo_off);
        moc_pkg::OFS_DIVISOR: O_PRDATA <= 32'(total_pulse_divisor);
        moc_pkg::OFS_EXPONENT: O_PRDATA <= 32'(total_decade_exponent);
        moc_pkg::OFS_FULL_SCALE: O_PRDATA <= 32'(full_scale);
        moc_pkg::OFS_STATUS: O_PRDATA <= status_word;
        moc_pkg::OFS_TOTAL: O_PRDATA <= total;
        default: O_PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // configuration writes take effect at the completing access edge only
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      mode1 <= moc_pkg::MODE_NONE;
      mode2 <= moc_pkg::MODE_NONE;
      rate_on <= moc_pkg::RATE_ON_RST;
      rate_off <= moc_pkg::RATE_OFF_RST;
      echo_on <= moc_pkg::ECHO_ON_RST;
      echo_off <= moc_pkg::ECHO_OFF_RST;
      total_pulse_divisor <= moc_pkg::DIVISOR_RST;
      total_decade_exponent <= '0;
      full_scale <= moc_pkg::FULL_SCALE_RST;
    end
    else if (wr_take)
    begin
      unique case (I_PADDR)
        moc_pkg::OFS_CTRL:
        begin
          mode1 <= I_PWDATA[moc_pkg::CTRL_OUT1_LSB +: moc_pkg::MODE_W];
          mode2 <= I_PWDATA[moc_pkg::CTRL_OUT2_LSB +: moc_pkg::MODE_W];
        end
        moc_pkg::OFS_RATE_ON: rate_on <= I_PWDATA[moc_pkg::RATE_W-1:0];
        moc_pkg::OFS_RATE_OFF: rate_off <= I_PWDATA[moc_pkg::RATE_W-1:0];
        moc_pkg::OFS_ECHO_ON: echo_on <= I_PWDATA[moc_pkg::ECHO_W-1:0];
        moc_pkg::OFS_ECHO_OFF: echo_off <= I_PWDATA[moc_pkg::ECHO_W-1:0];
        moc_pkg::OFS_DIVISOR: total_pulse_divisor <= I_PWDATA[moc_pkg::RATE_W-1:0];
        moc_pkg::OFS_EXPONENT: total_decade_exponent <= I_PWDATA[moc_pkg::EXP_W-1:0];
        moc_pkg::OFS_FULL_SCALE: full_scale <= I_PWDATA[moc_pkg::RATE_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // rate alarm: switch on at or above the on point, off at or below the off point
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rate_alarm <= 1'b0;
    end
    else
    begin
      rate_alarm <= hyst(rate_alarm, I_FLOW_RATE >= rate_on, I_FLOW_RATE <= rate_off);
    end
  end

  // echo alarm works the other way: a falling level trips it, a recovered level clears it
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      echo_level_alarm <= 1'b0;
    end
    else
    begin
      echo_level_alarm <= hyst(echo_level_alarm, I_ECHO_LEVEL <= echo_on, I_ECHO_LEVEL >= echo_off);
    end
  end

  // one displayed count per 10^exponent raw ticks, one pulse request per divisor counts
  assign disp_inc = I_TOTAL_TICK && (decade_cnt + 24'h00_0001 >= pow10(total_decade_exponent));
  // a zero divisor behaves as one so the chain never stalls
  assign pulse_req = disp_inc && (div_cnt + 16'h0001 >= total_pulse_divisor);

  // totalizer chain; the reset-total level clears the counters and total but not pending, and a tick in that cycle is not totalled but can still request a pulse
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      decade_cnt <= '0;
      div_cnt <= '0;
      total <= 32'h0000_0000;
    end
    else if (!I_NRESET_TOTAL)
    begin
      decade_cnt <= '0;
      div_cnt <= '0;
      total <= 32'h0000_0000;
    end
    else if (I_TOTAL_TICK)
    begin
      decade_cnt <= disp_inc ? 24'h00_0000 : decade_cnt + 24'h00_0001;
      if (disp_inc)
      begin
        total <= total + 32'h0000_0001;
        div_cnt <= pulse_req ? 16'h0000 : div_cnt + 16'h0001;
      end
    end
  end

  assign pulse_start = (tp_state == moc_pkg::TP_IDLE) && (pending != '0);

  // owed pulses: a request and a start in one cycle cancel, the count saturates rather than wraps
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pending <= '0;
    end
    else if (pulse_req && !pulse_start && pending != '1)
    begin
      pending <= pending + 16'h0001;
    end
    else if (!pulse_req && pulse_start)
    begin
      pending <= pending - 16'h0001;
    end
  end

  // pulse sequencer: high for the pulse width, then hold off until a full period has passed
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      tp_state <= moc_pkg::TP_IDLE;
      tp_timer <= 32'h0000_0000;
    end
    else
    begin
      unique case (tp_state)
        moc_pkg::TP_IDLE:
        begin
          tp_timer <= 32'h0000_0000;
          if (pulse_start)
          begin
            tp_state <= moc_pkg::TP_HIGH;
          end
        end
        moc_pkg::TP_HIGH:
        begin
          tp_timer <= tp_timer + 32'h0000_0001;
          if (tp_timer == 32'(P_PULSE_CYC - 1))
          begin
            tp_state <= moc_pkg::TP_GAP;
          end
        end
        moc_pkg::TP_GAP:
        begin
          tp_timer <= tp_timer + 32'h0000_0001;
          if (tp_timer == 32'(P_PERIOD_CYC - 1))
          begin
            tp_state <= moc_pkg::TP_IDLE;
          end
        end
      endcase
    end
  end

  assign tot_pulse = (tp_state == moc_pkg::TP_HIGH);

  // control outputs; the service cable overrides every function
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_CTRL_OUT1 <= 1'b0;
      O_CTRL_OUT2 <= 1'b0;
    end
    else
    begin
      O_CTRL_OUT1 <= ~I_USB_CONNECTED & out_level(mode1, rate_alarm, echo_level_alarm, tot_pulse, I_FAULT);
      O_CTRL_OUT2 <= ~I_USB_CONNECTED & out_level(mode2, rate_alarm, echo_level_alarm, tot_pulse, I_FAULT);
    end
  end

  assign fif.rate = I_FLOW_RATE;
  assign fif.full = full_scale;
  assign fif.en = ~I_USB_CONNECTED;
  assign fif.sq_sel = I_FREQ_WAVEFORM_SELECT_SWITCH;

  moc_freq_gen u_freq (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .fif(fif.gen)
  );

  // frequency pins and serial enable, re-timed so every pin leaves a flip-flop
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_FREQ_SQUARE <= 1'b0;
      O_FREQ_TURBINE <= 1'b0;
      O_RS485_ENABLE <= 1'b0;
    end
    else
    begin
      O_FREQ_SQUARE <= fif.sq & ~I_USB_CONNECTED;
      O_FREQ_TURBINE <= fif.turb & ~I_USB_CONNECTED;
      O_RS485_ENABLE <= ~I_USB_CONNECTED;
    end
  end

  // helper counters for the pulse checks
  logic [31:0] hi_len;
  logic [31:0] since_rise;
  logic tot_d;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      hi_len <= 32'h0000_0000;
      since_rise <= 32'hffff_ffff;
      tot_d <= 1'b0;
    end
    else
    begin
      tot_d <= tot_pulse;
      hi_len <= tot_pulse ? hi_len + 32'h0000_0001 : 32'h0000_0000;
      if (tot_pulse && !tot_d)
      begin
        since_rise <= 32'h0000_0001;
      end
      else if (since_rise != 32'hffff_ffff)
      begin
        since_rise <= since_rise + 32'h0000_0001;
      end
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  chk_usb_ctrl_off: assert property (I_USB_CONNECTED |=> !O_CTRL_OUT1 && !O_CTRL_OUT2)
  else $error("control output active with service cable attached");
  chk_usb_freq_off: assert property (I_USB_CONNECTED |=> !O_FREQ_SQUARE && !O_FREQ_TURBINE && !O_RS485_ENABLE)
  else $error("frequency or serial port live with service cable attached");
  chk_rate_alarm_on: assert property ((mode1 == moc_pkg::MODE_RATE && !I_USB_CONNECTED && I_FLOW_RATE >= rate_on)
    ##1 !I_USB_CONNECTED |=> O_CTRL_OUT1)
  else $error("rate alarm did not switch on");
  chk_rate_alarm_hold: assert property ((I_FLOW_RATE < rate_on && I_FLOW_RATE > rate_off)
    |=> rate_alarm == $past(rate_alarm))
  else $error("rate alarm changed inside the deadband");
  chk_echo_alarm_on: assert property ((I_ECHO_LEVEL <= echo_on) |=> echo_level_alarm)
  else $error("echo alarm missed a weak signal");
  chk_error_follow: assert property ((mode2 == moc_pkg::MODE_ERROR && !I_USB_CONNECTED) |=> O_CTRL_OUT2 == $past(I_FAULT))
  else $error("error output does not follow the fault");
  chk_total_clear: assert property (!I_NRESET_TOTAL |=> total == 32'h0000_0000 && div_cnt == '0)
  else $error("total not cleared by reset-total input");
  chk_pulse_width: assert property ($fell(tot_pulse) |-> hi_len == 32'(P_PULSE_CYC))
  else $error("totalizer pulse width wrong");
  chk_pulse_spacing: assert property ($rose(tot_pulse) |-> since_rise >= 32'(P_PERIOD_CYC))
  else $error("totalizer pulses closer than one period");
  chk_pending_keep: assert property ((pulse_req && !pulse_start && pending != '1) |=> pending == $past(pending) + 16'h0001)
  else $error("totalizer request lost");
endmodule

/* verif/moc_instr_model.sv */
// receiving instrument: counts control pulses and frequency edges
module moc_instr_model (
  input wire logic i_clk,
  input wire logic i_pulse,
  input wire logic i_sq,
  input wire logic i_turb,
  output int o_pulses,
  output int o_width,
  output int o_gap,
  output int o_period,
  output int o_turb
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0; // free-running cycle count
  int t_rise = -100000; // last pulse rise, far past so the first gap is large
  int t_sq = 0; // last square rise
  int w = 0; // high cycles of the current pulse
  logic p_q = 1'b0;
  logic sq_q = 1'b0;
  logic tb_q = 1'b0;
  initial
  begin
    o_pulses = 0;
    o_width = 0;
    o_gap = 1000000;
    o_period = 0;
    o_turb = 0;
  end
  // sampled at the rising edge, so it sees the design's settled outputs
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    p_q <= i_pulse;
    sq_q <= i_sq;
    tb_q <= i_turb;
    // count pulses and keep the tightest rise-to-rise spacing
    if (i_pulse && !p_q)
    begin
      o_pulses <= o_pulses + 1;
      if (cyc - t_rise < o_gap)
        o_gap <= cyc - t_rise;
      t_rise <= cyc;
      w <= 1;
    end
    else if (i_pulse)
      w <= w + 1;
    if (!i_pulse && p_q)
      o_width <= w;
    if (i_sq && !sq_q)
    begin
      o_period <= cyc - t_sq;
      t_sq <= cyc;
    end
    if (i_turb && !tb_q)
      o_turb <= o_turb + 1;
  end
endmodule

/* verif/test_meter_output_control_logic.sv */
module test_meter_output_control_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, psel, pen, pwr, tick, fault, usb, nrt, sw;
  logic [7:0] paddr, echo;
  logic [15:0] flow;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, out1, out2, fsq, ftb, rs485;
  int n_mismatch = 0;
  int cmp_count = 0;
  int pulses, width, gap, period, turbs, k;
  // short pulse and period keep the totalizer run brief
  moc_top #(.P_PULSE_CYC(4), .P_PERIOD_CYC(20)) u_dut (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_FLOW_RATE(flow), .I_ECHO_LEVEL(echo),
    .I_TOTAL_TICK(tick), .I_FAULT(fault), .I_USB_CONNECTED(usb), .I_NRESET_TOTAL(nrt),
    .I_FREQ_WAVEFORM_SELECT_SWITCH(sw), .O_CTRL_OUT1(out1), .O_CTRL_OUT2(out2),
    .O_FREQ_SQUARE(fsq), .O_FREQ_TURBINE(ftb), .O_RS485_ENABLE(rs485));
  moc_instr_model u_inst (.i_clk(clk), .i_pulse(out1), .i_sq(fsq), .i_turb(ftb), .o_pulses(pulses),
    .o_width(width), .o_gap(gap), .o_period(period), .o_turb(turbs));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; the request stands until pready is sampled high at a rising edge,
  // read data and error are taken at that edge; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    chk("apb error flag", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(name, exp, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // four input levels against the alarm output, on flow or echo level
  task automatic walk(input bit e, input int v[4], input logic [3:0] ex);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      if (e)
        echo <= v[i][7:0];
      else
        flow <= v[i][15:0];
      cyc(4);
      chk("alarm output", {31'h0, ex[i]}, {31'h0, out1});
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog well beyond the longest expected run
  initial
  begin
    #(100000 * 50);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    {nrst, psel, pen, pwr, tick, fault, usb} = 7'h0;
    {nrt, sw} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    flow = 16'h0000;
    echo = 8'h20;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdchk(moc_pkg::OFS_RATE_ON, 32'h0000ffff, "rate on reset");
    rdchk(moc_pkg::OFS_ECHO_OFF, 32'h0000000a, "echo off reset");
    rdchk(moc_pkg::OFS_FULL_SCALE, 32'h00000190, "full scale reset");
    apb(1'b0, 8'h40, 32'h0, 1'b1);
    chk("unmapped read", 32'h0, rd);
    apb(1'b1, moc_pkg::OFS_RATE_ON, 32'h64, 1'b0);
    apb(1'b1, moc_pkg::OFS_RATE_OFF, 32'h32, 1'b0);
    apb(1'b1, moc_pkg::OFS_CTRL, 32'h41, 1'b0);
    walk(1'b0, '{120, 70, 50, 70}, 4'b0011);
    chk("error output idle", 32'h0, {31'h0, out2});
    @(posedge clk);
    fault <= 1'b1;
    cyc(3);
    chk("error output", 32'h1, {31'h0, out2});
    @(posedge clk);
    usb <= 1'b1;
    cyc(3);
    chk("cable output off", 32'h0, {31'h0, out2});
    chk("cable serial off", 32'h0, {31'h0, rs485});
    @(posedge clk);
    {usb, fault} <= 2'b00;
    apb(1'b1, moc_pkg::OFS_CTRL, 32'h02, 1'b0);
    chk("cable serial back", 32'h1, {31'h0, rs485});
    walk(1'b1, '{3, 7, 12, 7}, 4'b0011);
    apb(1'b1, moc_pkg::OFS_CTRL, 32'h03, 1'b0);
    apb(1'b1, moc_pkg::OFS_EXPONENT, 32'h1, 1'b0);
    apb(1'b1, moc_pkg::OFS_DIVISOR, 32'h1, 1'b0);
    // the alarm walks above already raised output one, so count only what follows
    k = pulses;
    @(posedge clk);
    tick <= 1'b1;
    repeat (40) @(posedge clk);
    tick <= 1'b0;
    cyc(120);
    chk("pulse count", 32'h4, pulses - k);
    chk("pulse width", 32'h4, width);
    chk("pulse spacing", 32'h1, {31'h0, gap >= 21});
    rdchk(moc_pkg::OFS_TOTAL, 32'h4, "total");
    @(posedge clk);
    nrt <= 1'b0;
    cyc(3);
    @(posedge clk);
    nrt <= 1'b1;
    rdchk(moc_pkg::OFS_TOTAL, 32'h0, "total cleared");
    // full-scale rate: 1000 Hz is 20000 cycles at 20 MHz
    @(posedge clk);
    flow <= 16'h0190;
    cyc(50000);
    chk("freq period", 32'h1, {31'h0, period >= 19998 && period <= 20002});
    @(posedge clk);
    sw <= 1'b0;
    k = turbs;
    cyc(21000);
    chk("turbine running", 32'h1, {31'h0, turbs > k});
    chk("square idle", 32'h0, {31'h0, fsq});
    print_verdict();
  end
endmodule
